// ### hdl/hwrc_map.svh
`ifndef HWRC_MAP_SVH
`define HWRC_MAP_SVH

// Start-up idle time, in system clock periods
`define HWRC_STARTUP_CLOCKS 1024
// ref_clk runs at the system clock rate, so one period is one cycle
`define HWRC_STARTUP_CYCLES (`HWRC_STARTUP_CLOCKS * 1)
`define HWRC_STARTUP_W      11

// Register reset values and watchdog select field layout
`define HWRC_PORT_RST       8'hff
`define HWRC_WDSEL_RST      8'h87
`define HWRC_WDSEL_HI_FIXED 5'h10
`define HWRC_WS_MSB         2
`define HWRC_WS_HI_LSB      3

// Watchdog geometry
`define HWRC_WDT_BASE_BITS  8
`define HWRC_WDT_W          15
`define HWRC_INSTR_DIV_LAST 2'h3

`endif

// ### hdl/hwrc_pkg.sv
`default_nettype none

package hwrc_pkg;

  typedef enum logic [1:0] {
    HWRC_RESET_DELAY = 2'b00,
    HWRC_RUN         = 2'b01,
    HWRC_SLEEP       = 2'b10,
    HWRC_WAKE_DELAY  = 2'b11
  } hwrc_mode_t;

  // Core writes to the port and watchdog select registers
  typedef struct packed {
    logic       portDataWr;
    logic       portDirWr;
    logic       wdtSelWr;
    logic [7:0] data;
  } hwrc_reg_wr_t;

  // Interrupt request and enable view from the core
  typedef struct packed {
    logic [1:0] req;
    logic [1:0] enable;
    logic       master;
    logic       stackFull;
  } hwrc_irq_t;

  typedef struct packed {
    hwrc_mode_t  mode;
    logic [10:0] startupCount;
    logic [14:0] wdtCount;
    logic [1:0]  instrDiv;
    logic        timeoutFlag;
    logic        powerdownFlag;
    logic        sysOscEnable;
    logic        coreHold;
    logic        chipReset;
    logic        warmReset;
    logic        resumeNext;
    logic        irqPending;
    logic        irqLater;
    logic        irqAccept;
    logic [1:0]  irqArm;
    logic [7:0]  portData;
    logic [7:0]  portDir;
    logic [7:0]  wdtSelect;
    logic [2:0]  rstSync;
    logic        rstStable;
    logic [7:0]  paSync1;
    logic [7:0]  paSync2;
    logic [7:0]  paSync3;
    logic [7:0]  paStable;
    logic [2:0]  rcSync;
    logic        rcStable;
  } hwrc_state_t;

endpackage

`default_nettype wire

// ### hdl/hwrc_halt_wakeup_reset_control.sv
// Summary of operation
// - Sleep instruction stops the system oscillator; watchdog RC clock keeps running.
// - RAM and register contents stay unaltered throughout sleep.
// - Sleep entry clears watchdog counter when RC clocked.
// - Port outputs and directions hold their pre-sleep state during sleep.
// - Sleep instruction sets power-down flag and clears timeout flag.
// - Leave sleep on reset pin, interrupt, port A fall, watchdog overflow.
// - Reset pin always gives full initialisation, awake or asleep.
// - Power-down flag cleared by power-up or watchdog clear, set by sleep.
// - Watchdog timeout in sleep sets timeout, wakes, resets only PC and SP.
// - Per-bit build-time port A wake mask; port wake resumes next instruction.
// - Interrupt wake continues next if disabled or stack full, else vectors.
// - Interrupt already requested at sleep entry cannot wake that sleep.
// - Wake inserts 1024 idle clocks, then resumes or starts interrupt later.
// - Start-up delay of 1024 clocks after every reset and every wake.
// - Reset causes: pin awake, pin asleep, watchdog awake, USB bus reset.
// - Flags: pin gives 0/0, watchdog awake 1/unchanged, watchdog wake 1/1.
// - Chip reset: PC zero, interrupts off, watchdog cleared, timer off, ports input.
// - Non-warm resets load ports with ff and watchdog select with 87.
// - Watchdog overflow in run mode gives full chip reset and sets timeout.
`include "hwrc_map.svh"
`default_nettype none

module hwrc_halt_wakeup_reset_control #(
  parameter logic [7:0] PA_WAKE_MASK   = 8'hff,
  parameter int         STARTUP_CYCLES = `HWRC_STARTUP_CYCLES
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // Pins
  input  wire logic                  extRstNPin,
  input  wire logic [7:0]            portAPins,
  input  wire logic                  wdtRcClkPin,
  // Core side
  input  wire logic                  sleepInstr,
  input  wire logic                  wdtClearInstr,
  input  wire hwrc_pkg::hwrc_reg_wr_t regWr,
  input  wire hwrc_pkg::hwrc_irq_t   irq,
  input  wire logic                  usbBusReset,
  // Options
  input  wire logic                  wdtEnable,
  input  wire logic                  wdtUseRc,
  // Control outputs
  output logic                       sysOscEnable,
  output logic                       coreHold,
  output logic                       chipReset,
  output logic                       warmReset,
  output logic                       resumeNext,
  output logic                       irqAccept,
  // Status and registers
  output logic                       timeoutFlag,
  output logic                       powerdownFlag,
  output logic [7:0]                 portData,
  output logic [7:0]                 portDir,
  output logic [7:0]                 wdtSelect
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [14:0] wdt_limit(input logic [2:0] ws);
    logic [16:0] full;
    full = (17'h1 << (`HWRC_WDT_BASE_BITS + ws)) - 17'h1;
    return full[14:0];
  endfunction

  function automatic hwrc_pkg::hwrc_state_t full_init(input hwrc_pkg::hwrc_state_t s);
    hwrc_pkg::hwrc_state_t r;
    r              = s;
    r.mode         = hwrc_pkg::HWRC_RESET_DELAY;
    r.startupCount = '0;
    r.wdtCount     = '0;
    r.instrDiv     = '0;
    r.portData     = `HWRC_PORT_RST;
    r.portDir      = `HWRC_PORT_RST;
    r.wdtSelect    = `HWRC_WDSEL_RST;
    r.chipReset    = 1'b1;
    r.coreHold     = 1'b1;
    r.sysOscEnable = 1'b1;
    r.irqPending   = 1'b0;
    r.irqLater     = 1'b0;
    return r;
  endfunction

  localparam hwrc_pkg::hwrc_state_t RESET_ST = '{
    mode:          hwrc_pkg::HWRC_RESET_DELAY,
    startupCount:  '0,
    wdtCount:      '0,
    instrDiv:      '0,
    timeoutFlag:   1'b0,
    powerdownFlag: 1'b0,
    sysOscEnable:  1'b1,
    coreHold:      1'b1,
    chipReset:     1'b1,
    warmReset:     1'b0,
    resumeNext:    1'b0,
    irqPending:    1'b0,
    irqLater:      1'b0,
    irqAccept:     1'b0,
    irqArm:        '0,
    portData:      `HWRC_PORT_RST,
    portDir:       `HWRC_PORT_RST,
    wdtSelect:     `HWRC_WDSEL_RST,
    rstSync:       '0,
    rstStable:     1'b0,
    paSync1:       `HWRC_PORT_RST,
    paSync2:       `HWRC_PORT_RST,
    paSync3:       `HWRC_PORT_RST,
    paStable:      `HWRC_PORT_RST,
    rcSync:        '0,
    rcStable:      1'b0
  };

  localparam logic [10:0] STARTUP_LAST = 11'(STARTUP_CYCLES - 1);

  hwrc_pkg::hwrc_state_t st;
  hwrc_pkg::hwrc_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Filtered pin events

  logic [7:0]  paAgree;
  logic [7:0]  paFall;
  logic        rcAgree;
  logic        rcRise;
  logic        asleep;
  logic        instrTick;
  logic        wdtTick;
  logic [14:0] wdtLimit;
  logic        wdtOverflow;
  logic        quiet;
  logic        portWake;
  logic [1:0]  armedReq;
  logic        irqWake;
  logic        sleepEntry;

  // Edges sampled on ref_clk, which keeps running while the system oscillator is off
  assign paAgree     = ~(st.paSync2 ^ st.paSync3);
  assign paFall      = st.paStable & paAgree & ~st.paSync2;
  assign rcAgree     = ~(st.rcSync[1] ^ st.rcSync[2]);
  assign rcRise      = rcAgree & st.rcSync[1] & ~st.rcStable;
  assign asleep      = (st.mode == hwrc_pkg::HWRC_SLEEP);
  assign instrTick   = !asleep && (st.instrDiv == `HWRC_INSTR_DIV_LAST);
  assign wdtTick     = wdtEnable && (wdtUseRc ? rcRise : instrTick);
  assign wdtLimit    = wdt_limit(st.wdtSelect[`HWRC_WS_MSB:0]);
  assign wdtOverflow = wdtTick && (st.wdtCount == wdtLimit);
  assign quiet       = st.rstStable && !usbBusReset;
  assign portWake    = |(paFall & PA_WAKE_MASK);
  assign armedReq    = irq.req & st.irqArm;
  assign irqWake     = |armedReq;
  assign sleepEntry  = quiet && (st.mode == hwrc_pkg::HWRC_RUN) && !wdtOverflow && sleepInstr;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st            = st;
    next_st.chipReset  = 1'b0;
    next_st.warmReset  = 1'b0;
    next_st.resumeNext = 1'b0;
    next_st.irqAccept  = st.irqLater;
    next_st.irqLater   = 1'b0;

    next_st.rstSync = {st.rstSync[1:0], extRstNPin};
    if (st.rstSync[2] == st.rstSync[1]) begin
      next_st.rstStable = st.rstSync[1];
    end
    next_st.paSync1  = portAPins;
    next_st.paSync2  = st.paSync1;
    next_st.paSync3  = st.paSync2;
    next_st.paStable = (st.paStable & ~paAgree) | (st.paSync2 & paAgree);
    next_st.rcSync   = {st.rcSync[1:0], wdtRcClkPin};
    if (rcAgree) begin
      next_st.rcStable = st.rcSync[1];
    end

    if (!asleep) begin
      next_st.instrDiv = st.instrDiv + 2'h1;
    end
    if (wdtTick) begin
      next_st.wdtCount = wdtOverflow ? '0 : st.wdtCount + 15'h1;
    end

    if (!st.rstStable) begin
      next_st               = full_init(next_st);
      next_st.timeoutFlag   = 1'b0;
      next_st.powerdownFlag = 1'b0;
    end else if (usbBusReset) begin
      next_st = full_init(next_st);
      if (asleep) begin
        next_st.timeoutFlag = 1'b0;
      end
    end else begin
      case (st.mode)
        hwrc_pkg::HWRC_RESET_DELAY,
        hwrc_pkg::HWRC_WAKE_DELAY: begin
          next_st.startupCount = st.startupCount + 11'h1;
          if (st.startupCount == STARTUP_LAST) begin
            next_st.mode         = hwrc_pkg::HWRC_RUN;
            next_st.coreHold     = 1'b0;
            next_st.startupCount = '0;
            next_st.irqPending = 1'b0;
            if (st.mode == hwrc_pkg::HWRC_WAKE_DELAY) begin
              next_st.resumeNext = 1'b1;
              next_st.irqLater   = st.irqPending;
            end
          end
        end
        hwrc_pkg::HWRC_RUN: begin
          if (wdtOverflow) begin
            next_st             = full_init(next_st);
            next_st.timeoutFlag = 1'b1;
          end else if (sleepInstr) begin
            next_st.mode          = hwrc_pkg::HWRC_SLEEP;
            next_st.sysOscEnable  = 1'b0;
            next_st.coreHold      = 1'b1;
            next_st.powerdownFlag = 1'b1;
            next_st.timeoutFlag   = 1'b0;
            next_st.irqArm        = ~irq.req;
            if (wdtUseRc) begin
              next_st.wdtCount = '0;
            end
          end else begin
            if (wdtClearInstr) begin
              next_st.powerdownFlag = 1'b0;
              next_st.wdtCount      = '0;
            end
            if (regWr.portDataWr) begin
              next_st.portData = regWr.data;
            end
            if (regWr.portDirWr) begin
              next_st.portDir = regWr.data;
            end
            if (regWr.wdtSelWr) begin
              next_st.wdtSelect = {`HWRC_WDSEL_HI_FIXED, regWr.data[`HWRC_WS_MSB:0]};
            end
          end
        end
        hwrc_pkg::HWRC_SLEEP: begin
          // Registers and ports are left untouched here
          if (wdtOverflow) begin
            next_st.mode          = hwrc_pkg::HWRC_WAKE_DELAY;
            next_st.sysOscEnable  = 1'b1;
            next_st.warmReset     = 1'b1;
            next_st.timeoutFlag   = 1'b1;
            next_st.powerdownFlag = 1'b1;
            next_st.irqPending    = 1'b0;
          end else if (irqWake || portWake) begin
            next_st.mode         = hwrc_pkg::HWRC_WAKE_DELAY;
            next_st.sysOscEnable = 1'b1;
            next_st.irqPending   = irqWake && irq.master && !irq.stackFull
                                   && |(armedReq & irq.enable);
          end
        end
        default: begin
          next_st = full_init(next_st);
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= RESET_ST;
    end else begin
      st <= next_st;
    end
  end

  assign sysOscEnable  = st.sysOscEnable;
  assign coreHold      = st.coreHold;
  assign chipReset     = st.chipReset;
  assign warmReset     = st.warmReset;
  assign resumeNext    = st.resumeNext;
  assign irqAccept     = st.irqAccept;
  assign timeoutFlag   = st.timeoutFlag;
  assign powerdownFlag = st.powerdownFlag;
  assign portData      = st.portData;
  assign portDir       = st.portDir;
  assign wdtSelect     = st.wdtSelect;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence sleep_enter_s;
    sleepEntry;
  endsequence

  sequence asleep_twice_s;
    (asleep && quiet && !wdtOverflow && !irqWake && !portWake)[*2];
  endsequence

  sequence wdt_wake_s;
    asleep && quiet && wdtOverflow;
  endsequence

  sleep_osc_off_a: assert property (sleep_enter_s |=> !sysOscEnable && coreHold)
    else $error("oscillator not stopped on sleep");

  sleep_hold_a: assert property (asleep_twice_s |->
                                 $stable(portData) && $stable(portDir) && $stable(wdtSelect))
    else $error("registers changed during sleep");

  sleep_wdt_clr_a: assert property (sleep_enter_s and wdtUseRc |=> st.wdtCount == '0)
    else $error("watchdog not cleared on sleep entry");

  sleep_flags_a: assert property (sleep_enter_s |=> powerdownFlag && !timeoutFlag)
    else $error("flags wrong after sleep entry");

  port_wake_a: assert property (asleep && quiet && !wdtOverflow && portWake
                                |=> st.mode == hwrc_pkg::HWRC_WAKE_DELAY && sysOscEnable)
    else $error("port fall did not wake");

  pin_init_a: assert property (!st.rstStable |=> chipReset
                               && portDir == `HWRC_PORT_RST && !timeoutFlag && !powerdownFlag)
    else $error("reset pin did not initialise");

  powerdown_clear_a: assert property (quiet && st.mode == hwrc_pkg::HWRC_RUN
                                      && !wdtOverflow && !sleepInstr && wdtClearInstr
                                      |=> !powerdownFlag)
    else $error("watchdog clear kept power-down flag");

  warm_reset_a: assert property (wdt_wake_s |=> warmReset && !chipReset
                                 && timeoutFlag && powerdownFlag && $stable(portData))
    else $error("watchdog wake not a warm reset");

  no_stale_irq_a: assert property (asleep && quiet && !wdtOverflow && !portWake
                                   && (irq.req & st.irqArm) == 2'b00 |=> asleep)
    else $error("left sleep without a wake source");

  stale_irq_arm_a: assert property (sleep_enter_s
                                    |=> (st.irqArm & $past(irq.req)) == 2'b00)
    else $error("pending interrupt armed for wake");

  wake_delay_a: assert property (resumeNext
                                 |-> $past(st.mode) == hwrc_pkg::HWRC_WAKE_DELAY
                                 && $past(st.startupCount) == STARTUP_LAST)
    else $error("wake delay length wrong");

  irq_after_a: assert property (irqAccept |-> $past(resumeNext) && !coreHold)
    else $error("interrupt taken outside resume");

  wdt_run_rst_a: assert property (quiet && st.mode == hwrc_pkg::HWRC_RUN
                                  && wdtOverflow |=> chipReset && timeoutFlag
                                  && powerdownFlag == $past(powerdownFlag))
    else $error("watchdog overflow in run mishandled");

endmodule // hwrc_halt_wakeup_reset_control

`default_nettype wire

// ### tb/hwrc_core_model.sv
`default_nettype none

module hwrc_core_model (
  // Requests from the bench
  input  wire logic       rstPinReq,
  input  wire logic [7:0] paDrive,
  // Pins toward the block
  output logic            extRstNPin,
  output logic [7:0]      portAPins,
  output var logic        wdtRcClkPin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Reset pin and port A have pull-ups: released means high
  assign extRstNPin = ~rstPinReq;
  assign portAPins  = paDrive;

  // Free-running RC clock, phase unrelated to ref_clk
  initial begin
    wdtRcClkPin = 1'b0;
    #37;
    forever #110 wdtRcClkPin = ~wdtRcClkPin;
  end
endmodule // hwrc_core_model

`default_nettype wire

// ### tb/halt_wakeup_reset_control_tb.sv
`default_nettype none

module halt_wakeup_reset_control_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int STARTUP = 8;

  logic                   ref_clk, rst, sleepInstr, wdtClearInstr, usbBusReset;
  logic                   wdtEnable, wdtUseRc, extRstNPin, wdtRcClkPin, rstPinReq;
  logic [7:0]             portAPins, paDrive, portData, portDir, wdtSelect;
  logic                   sysOscEnable, coreHold, chipReset, warmReset;
  logic                   resumeNext, irqAccept, timeoutFlag, powerdownFlag;
  hwrc_pkg::hwrc_reg_wr_t regWr;
  hwrc_pkg::hwrc_irq_t    irq;
  int                     mismatches = 0;
  int                     compares = 0;

  hwrc_halt_wakeup_reset_control #(
    .PA_WAKE_MASK  (8'h01),
    .STARTUP_CYCLES(STARTUP)
  ) dut (
    .ref_clk, .rst, .extRstNPin, .portAPins, .wdtRcClkPin, .sleepInstr,
    .wdtClearInstr, .regWr, .irq, .usbBusReset, .wdtEnable, .wdtUseRc,
    .sysOscEnable, .coreHold, .chipReset, .warmReset, .resumeNext, .irqAccept,
    .timeoutFlag, .powerdownFlag, .portData, .portDir, .wdtSelect
  );

  hwrc_core_model model (.rstPinReq, .paDrive, .extRstNPin, .portAPins, .wdtRcClkPin);

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (mismatches == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chkFlags(input logic expTimeout, input logic expPowerdown);
    chk("flags", {6'h0, timeoutFlag, powerdownFlag}, {6'h0, expTimeout, expPowerdown});
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return resumeNext;
      1: return ~coreHold;
      2: return warmReset;
      3: return chipReset;
      default: return sysOscEnable;
    endcase
  endfunction

  task automatic waitFor(input int w, input int lim, output int n);
    n = 0;
    while (pick(w) !== 1'b1 && n < lim) begin
      step(1);
      n++;
    end
    chk("waitDone", {7'h0, pick(w)}, 8'h01);
  endtask

  task automatic wr(input logic [2:0] strobes, input logic [7:0] d);
    regWr = {strobes, d};
    step(1);
    regWr = '0;
    // Let an edge pass so a following write never re-raises a strobe in the same step
    step(1);
  endtask

  task automatic doSleep();
    sleepInstr = 1'b1;
    step(1);
    sleepInstr = 1'b0;
    chk("oscOff", {7'h0, sysOscEnable}, 8'h00);
    chkFlags(1'b0, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic testReset();
    int n;
    chk("rstInit", {7'h0, chipReset}, 8'h01);
    chk("rstData", portData, 8'hff);
    chk("rstDir", portDir, 8'hff);
    chk("rstWs", wdtSelect, 8'h87);
    chkFlags(1'b0, 1'b0);
    rst = 1'b0;
    waitFor(1, 40, n);
    chk("startDelay", {7'h0, n >= STARTUP && n <= STARTUP + 6}, 8'h01);
  endtask

  task automatic testPortWake();
    int n;
    wr(3'b100, 8'h5a);
    wr(3'b010, 8'h3c);
    doSleep();
    paDrive = 8'hfd;
    step(20);
    chk("maskedBit", {7'h0, sysOscEnable}, 8'h00);
    paDrive = 8'hfc;
    waitFor(4, 10, n);
    waitFor(0, 4 * STARTUP, n);
    chk("wakeDelay", 8'(n), 8'(STARTUP));
    chk("holdData", portData, 8'h5a);
    chk("holdDir", portDir, 8'h3c);
    chk("coreGo", {7'h0, coreHold}, 8'h00);
    paDrive = 8'hff;
    wdtClearInstr = 1'b1;
    step(1);
    wdtClearInstr = 1'b0;
    chkFlags(1'b0, 1'b0);
  endtask

  task automatic testIrqWake();
    int n;
    // Case 0 vectors, case 1 has the stack full, case 2 has the waking source disabled
    for (int sf = 0; sf < 3; sf++) begin
      irq = '{req: 2'b01, enable: (sf == 2) ? 2'b01 : 2'b11, master: 1'b1,
              stackFull: (sf == 1)};
      doSleep();
      step(20);
      chk("stalePend", {7'h0, sysOscEnable}, 8'h00);
      irq.req = 2'b11;
      waitFor(0, 4 * STARTUP + 10, n);
      step(1);
      chk("vector", {7'h0, irqAccept}, {7'h0, sf == 0});
      irq = '0;
      step(2);
    end
  endtask

  task automatic testWdt();
    int n;
    wr(3'b001, 8'h00);
    chk("wsForced", wdtSelect, 8'h80);
    wr(3'b100, 8'ha5);
    wdtUseRc = 1'b1;
    wdtEnable = 1'b1;
    step(600);
    doSleep();
    waitFor(2, 3000, n);
    chk("wdtRestart", {7'h0, n > 1300}, 8'h01);
    chkFlags(1'b1, 1'b1);
    chk("warmData", portData, 8'ha5);
    chk("warmWs", wdtSelect, 8'h80);
    waitFor(0, 4 * STARTUP + 10, n);
    waitFor(3, 3000, n);
    chkFlags(1'b1, 1'b1);
    waitFor(1, 40, n);
    chk("wdtData", portData, 8'hff);
    chk("wdtWs", wdtSelect, 8'h87);
    wdtEnable = 1'b0;
  endtask

  task automatic testPinAndUsb();
    int n;
    wr(3'b100, 8'h3c);
    doSleep();
    rstPinReq = 1'b1;
    step(6);
    chk("pinInit", {7'h0, chipReset}, 8'h01);
    rstPinReq = 1'b0;
    waitFor(1, 40, n);
    chkFlags(1'b0, 1'b0);
    chk("pinData", portData, 8'hff);
    chk("pinOsc", {7'h0, sysOscEnable}, 8'h01);
    wr(3'b100, 8'h77);
    usbBusReset = 1'b1;
    step(1);
    usbBusReset = 1'b0;
    waitFor(3, 5, n);
    waitFor(1, 40, n);
    chk("usbData", portData, 8'hff);
    chkFlags(1'b0, 1'b0);
    // Bus reset while asleep clears timeout but keeps power-down
    doSleep();
    usbBusReset = 1'b1;
    step(1);
    usbBusReset = 1'b0;
    waitFor(1, 40, n);
    chkFlags(1'b0, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    #400_000;
    mismatches++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    sleepInstr = 1'b0;
    wdtClearInstr = 1'b0;
    usbBusReset = 1'b0;
    wdtEnable = 1'b0;
    wdtUseRc = 1'b0;
    rstPinReq = 1'b0;
    paDrive = 8'hff;
    regWr = '0;
    irq = '0;
    step(20);
    testReset();
    testPortWake();
    testIrqWake();
    testWdt();
    testPinAndUsb();
    complete_run();
  end
endmodule // halt_wakeup_reset_control_tb

`default_nettype wire
